// >>> rtl/spr_unit.sv
// Secure page removal unit: leaf decode, page checks, map update and result.
`timescale 1ns/1ps
`include "spr_regs.svh"

module spr_unit (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic [7:0]             leaf_sel,
  input  wire spr_pkg::spr_mode_t     core_mode,
  output logic                        lookup_req,
  output logic      [63:0]            lookup_addr,
  input  wire spr_pkg::spr_lookup_t   lookup_rsp,
  output logic                        map_clear,
  output logic      [63:0]            map_addr,
  output logic                        track_start,
  output logic                        irq
);

  typedef enum logic [1:0] {
    SPR_ST_IDLE,
    SPR_ST_LOOK,
    SPR_ST_DONE
  } spr_state_t;

  spr_state_t           state;
  logic [63:0]          operand;
  logic [63:0]          linear;
  logic [7:0]           result;
  spr_pkg::spr_flags_t  flags;
  spr_pkg::spr_fault_t  fault;
  logic [15:0]          fault_code;
  logic [63:0]          exit_gpa;
  logic [63:0]          exit_gla;
  logic [31:0]          exit_info;
  logic [3:0]           irq_stat;
  logic [3:0]           irq_mask;
  logic [3:0]           wait_cnt;
  logic                 go;
  logic                 busy;
  logic [3:0]           ev;
  spr_pkg::spr_fault_t  next_fault;
  logic [15:0]          next_code;
  logic                 next_clear;
  logic                 next_ok;
  logic                 next_err;
  logic [7:0]           next_result;

  assign go   = reg_wr && reg_addr == `SPR_OFF_CTRL && reg_wdata[`SPR_CTRL_GO_BIT] && !busy;
  assign busy = state != SPR_ST_IDLE;

  // Data segment base is always used; overrides are not modelled at all.
  assign linear = operand + {32'h0, core_mode.ds_base};

  // ----------------------------------------------------------------
  // Operand register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      operand <= 64'h0;
    end else if (reg_wr && reg_addr == `SPR_OFF_OPERAND && !busy) begin
      operand[31:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == `SPR_OFF_OPERAND_HI && !busy) begin
      // The high word survives low-word writes, so a 64-bit operand takes two writes.
      operand[63:32] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Check sequence
  // ----------------------------------------------------------------
  // Decision of the whole check chain; order of the if-chain is the check order.
  always_comb begin
    next_fault  = spr_pkg::SPR_FLT_NONE;
    next_code   = 16'h0;
    next_clear  = 1'b0;
    next_ok     = 1'b0;
    next_err    = 1'b0;
    next_result = `SPR_RES_OK;
    if (core_mode.cpl != 2'h0) begin
      next_fault = spr_pkg::SPR_FLT_GP;
    end else if (leaf_sel == `SPR_LEAF_TRACK) begin
      next_ok = 1'b1;
    end else if (core_mode.long_mode && linear[63:47] != {17{linear[47]}}) begin
      next_fault = spr_pkg::SPR_FLT_GP;
    end else if (!core_mode.long_mode && operand[31:0] > core_mode.ds_limit) begin
      next_fault = spr_pkg::SPR_FLT_GP;
    end else if ((linear[11:0] & `SPR_PAGE_MASK) != 12'h0) begin
      next_fault = spr_pkg::SPR_FLT_GP;
    end else if (lookup_rsp.access_pf) begin
      next_fault = spr_pkg::SPR_FLT_PF;
      next_code  = lookup_rsp.pf_code;
    end else if (!lookup_rsp.in_cache) begin
      next_fault = spr_pkg::SPR_FLT_PF;
    end else if (lookup_rsp.conflict) begin
      next_fault = (core_mode.vm_guest && core_mode.virt_ext) ?
                   spr_pkg::SPR_FLT_VMEXIT : spr_pkg::SPR_FLT_GP;
    end else if (!lookup_rsp.entry.valid ||
                 (lookup_rsp.entry.ptype == spr_pkg::SPR_TRIMMED_PAGE_TYPE &&
                  !lookup_rsp.entry.modified)) begin
      next_ok = 1'b1;
    end else if (lookup_rsp.entry.ptype == spr_pkg::SPR_VERSION_ARRAY_TYPE) begin
      next_ok    = 1'b1;
      next_clear = 1'b1;
    end else if (lookup_rsp.entry.ptype == spr_pkg::SPR_CONTROL_STRUCTURE_TYPE) begin
      if (lookup_rsp.child_present ||
          (core_mode.vm_guest && core_mode.virt_ext && lookup_rsp.virt_child_nz)) begin
        next_err    = 1'b1;
        next_result = `SPR_RES_CHILD;
      end else begin
        next_ok    = 1'b1;
        next_clear = 1'b1;
      end
    end else if (lookup_rsp.enclave_active) begin
      next_err    = 1'b1;
      next_result = `SPR_RES_ACTIVE;
    end else begin
      next_ok    = 1'b1;
      next_clear = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // An unknown leaf code is ignored: the go write leaves the unit idle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state    <= SPR_ST_IDLE;
      wait_cnt <= 4'h0;
    end else begin
      unique case (state)
        SPR_ST_IDLE: begin
          if (go && (leaf_sel == `SPR_LEAF_REMOVE || leaf_sel == `SPR_LEAF_TRACK)) begin
            state    <= SPR_ST_LOOK;
            wait_cnt <= 4'(`SPR_LOOKUP_CYC);
          end
        end
        SPR_ST_LOOK: begin
          if (wait_cnt == 4'h1) begin
            state <= SPR_ST_DONE;
          end
          wait_cnt <= wait_cnt - 4'h1;
        end
        SPR_ST_DONE: begin
          state <= SPR_ST_IDLE;
        end
      endcase
    end
  end

  // A leaf refused for privilege must not reach the page map, and tracking needs no page here.
  assign lookup_req  = state == SPR_ST_LOOK && core_mode.cpl == 2'h0 &&
                       leaf_sel == `SPR_LEAF_REMOVE;
  assign lookup_addr = linear;

  // ----------------------------------------------------------------
  // Outcome registers
  // ----------------------------------------------------------------
  // A fault leaves result and flags unchanged, as an exception would.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result      <= `SPR_RES_OK;
      flags       <= '0;
      fault       <= spr_pkg::SPR_FLT_NONE;
      fault_code  <= 16'h0;
      map_clear   <= 1'b0;
      map_addr    <= 64'h0;
      track_start <= 1'b0;
    end else begin
      map_clear   <= 1'b0;
      track_start <= 1'b0;
      if (state == SPR_ST_DONE) begin
        fault      <= next_fault;
        fault_code <= next_code;
        if (next_fault == spr_pkg::SPR_FLT_NONE) begin
          flags <= '{zf: next_err, default: 1'b0};
          if (next_ok) begin
            result <= `SPR_RES_OK;
          end else begin
            result <= next_result;
          end
          track_start <= leaf_sel == `SPR_LEAF_TRACK;
          map_clear   <= next_clear && leaf_sel == `SPR_LEAF_REMOVE;
          map_addr    <= linear;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Hypervisor exit and page fault report
  // ----------------------------------------------------------------
  // The report stays until the next exit or code-zero page fault, so software may read it late.
  // The error field of the exit qualification is always zero.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exit_gpa  <= 64'h0;
      exit_gla  <= 64'h0;
      exit_info <= 32'h0;
    end else if (state == SPR_ST_DONE) begin
      if (next_fault == spr_pkg::SPR_FLT_VMEXIT) begin
        exit_gpa  <= lookup_rsp.phys_addr;
        exit_gla  <= linear;
        exit_info <= {16'h0, `SPR_QUAL_CONFLICT, `SPR_EXIT_REASON};
      end
      if (next_fault == spr_pkg::SPR_FLT_PF && next_code == 16'h0) begin
        exit_gla <= linear;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Events: 0 success, 1 error exit, 2 fault, 3 hypervisor exit.
  assign ev[0] = state == SPR_ST_DONE && next_fault == spr_pkg::SPR_FLT_NONE && !next_err;
  assign ev[1] = state == SPR_ST_DONE && next_fault == spr_pkg::SPR_FLT_NONE && next_err;
  assign ev[2] = state == SPR_ST_DONE && (next_fault == spr_pkg::SPR_FLT_GP ||
                                          next_fault == spr_pkg::SPR_FLT_PF);
  assign ev[3] = state == SPR_ST_DONE && next_fault == spr_pkg::SPR_FLT_VMEXIT;

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 4'h0;
    end else if (reg_wr && reg_addr == `SPR_OFF_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~reg_wdata[3:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 4'h0;
    end else if (reg_wr && reg_addr == `SPR_OFF_IRQ_MASK) begin
      irq_mask <= reg_wdata[3:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SPR_OFF_CTRL:     reg_rdata <= {31'h0, busy};
        `SPR_OFF_OPERAND:  reg_rdata <= operand[31:0];
        `SPR_OFF_STATUS:   reg_rdata <= {fault_code, 14'h0, fault};
        `SPR_OFF_RESULT:   reg_rdata <= {24'h0, result};
        `SPR_OFF_FLAGS:    reg_rdata <= {26'h0, flags};
        `SPR_OFF_IRQ_STAT: reg_rdata <= {28'h0, irq_stat};
        `SPR_OFF_IRQ_MASK: reg_rdata <= {28'h0, irq_mask};
        `SPR_OFF_EXIT_GPA: reg_rdata <= exit_gpa[31:0];
        `SPR_OFF_EXIT_GLA: reg_rdata <= exit_gla[31:0];
        `SPR_OFF_EXIT_INFO:  reg_rdata <= exit_info;
        `SPR_OFF_OPERAND_HI: reg_rdata <= operand[63:32];
        default:           reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_clear_needs_ok: assert property (@(posedge clk_sys) disable iff (!rst_n)
    map_clear |-> $past(next_ok) && $past(state) == SPR_ST_DONE)
    else $error("map clear without success");
  a_ok_result_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(ev[0]) |-> result == `SPR_RES_OK && !flags.zf && !flags.cf)
    else $error("success not reported");
  a_cpl_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && core_mode.cpl != 2'h0 |=> fault == spr_pkg::SPR_FLT_GP && !map_clear)
    else $error("nonzero privilege not refused");
  a_align_gp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && core_mode.cpl == 2'h0 && leaf_sel == `SPR_LEAF_REMOVE &&
    linear[11:0] != 12'h0 |=> fault != spr_pkg::SPR_FLT_NONE)
    else $error("unaligned operand accepted");
  a_child_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(ev[1]) |-> flags.zf && result != `SPR_RES_OK && !map_clear)
    else $error("error exit wrong");
  a_conflict_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(ev[3]) |-> fault == spr_pkg::SPR_FLT_VMEXIT &&
    $past(core_mode.vm_guest && core_mode.virt_ext) && exit_gpa == $past(lookup_rsp.phys_addr))
    else $error("exit outside guest");
  a_start_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && leaf_sel == `SPR_LEAF_REMOVE |=> state == SPR_ST_LOOK ##1 state == SPR_ST_DONE)
    else $error("removal did not run");
  a_track_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    track_start |=> !track_start)
    else $error("track start not a pulse");

  // ----------------------------------------------------------------
  // Assertions on faults and page decisions
  // ----------------------------------------------------------------
  a_canon_gp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && core_mode.cpl == 2'h0 && core_mode.long_mode &&
    leaf_sel == `SPR_LEAF_REMOVE && linear[63:47] != {17{linear[47]}} |=>
    fault == spr_pkg::SPR_FLT_GP && fault_code == 16'h0)
    else $error("noncanonical operand accepted");
  a_limit_gp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && core_mode.cpl == 2'h0 && !core_mode.long_mode &&
    leaf_sel == `SPR_LEAF_REMOVE && operand[31:0] > core_mode.ds_limit |=>
    fault == spr_pkg::SPR_FLT_GP)
    else $error("limit breach accepted");
  a_invalid_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && !lookup_rsp.entry.valid |=> !map_clear)
    else $error("invalid entry cleared");
  a_active_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && next_fault == spr_pkg::SPR_FLT_NONE &&
    leaf_sel == `SPR_LEAF_REMOVE && lookup_rsp.entry.valid && lookup_rsp.enclave_active &&
    (lookup_rsp.entry.ptype == spr_pkg::SPR_REGULAR_PAGE_TYPE ||
     lookup_rsp.entry.ptype == spr_pkg::SPR_THREAD_CONTROL_TYPE) |=>
    flags.zf && result == `SPR_RES_ACTIVE && !map_clear)
    else $error("active enclave not refused");
  a_pf_address: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && next_fault == spr_pkg::SPR_FLT_PF && !lookup_rsp.access_pf |=>
    fault == spr_pkg::SPR_FLT_PF && exit_gla == $past(linear))
    else $error("page fault address not reported");
  a_va_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && next_fault == spr_pkg::SPR_FLT_NONE &&
    leaf_sel == `SPR_LEAF_REMOVE && lookup_rsp.entry.valid &&
    lookup_rsp.entry.ptype == spr_pkg::SPR_VERSION_ARRAY_TYPE |=> map_clear && map_addr == $past(linear))
    else $error("version array page not cleared");
  a_virt_child: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && next_fault == spr_pkg::SPR_FLT_NONE &&
    leaf_sel == `SPR_LEAF_REMOVE && lookup_rsp.entry.valid &&
    lookup_rsp.entry.ptype == spr_pkg::SPR_CONTROL_STRUCTURE_TYPE && core_mode.vm_guest &&
    core_mode.virt_ext && lookup_rsp.virt_child_nz |=>
    flags.zf && result == `SPR_RES_CHILD && !map_clear)
    else $error("virtual child not counted");
  a_track_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == SPR_ST_DONE && leaf_sel == `SPR_LEAF_TRACK && core_mode.cpl != 2'h0 |=>
    fault == spr_pkg::SPR_FLT_GP && !track_start)
    else $error("tracking at nonzero privilege");

  c_remove_ok: cover property (@(posedge clk_sys) map_clear);
  c_child: cover property (@(posedge clk_sys) ev[1]);
  c_vmexit: cover property (@(posedge clk_sys) ev[3]);
  c_track: cover property (@(posedge clk_sys) track_start);
  c_fault: cover property (@(posedge clk_sys) ev[2]);

endmodule

// >>> pkg/spr_regs.svh
// Constants of the secure page removal unit: offsets, fields, codes and timing.
//
// Contract
// - Leaf code 03H starts page removal.
// - Page removal only at privilege zero.
// - Linear address from data segment only.
// - Unaligned operand gives protection fault zero.
// - Non-cache page gives page fault with address.
// - Conflict exits to hypervisor or protection faults.
// - Invalid or clean trimmed page: success, unchanged.
// - Version array page: clear valid, success.
// - Control page with children: child-present error.
// - Guest virtual child count counts as child.
// - Child page, active enclave: enclave-active error.
// - Child page types: clear valid, success.
// - Success zeroes result; clear arithmetic flags always (the unit clears them only on completion; a fault leaves them unchanged).
// - Protected mode limit breach: protection fault.
// - Noncanonical address in long mode: protection fault.
// - Operand access page fault is reported.
// - Leaf code 0CH starts tracking.
// - Tracking only at privilege zero.
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPR_OFF_CTRL     8'h00
`define SPR_OFF_OPERAND  8'h04
`define SPR_OFF_STATUS   8'h08
`define SPR_OFF_RESULT   8'h0c
`define SPR_OFF_FLAGS    8'h10
`define SPR_OFF_IRQ_STAT 8'h14
`define SPR_OFF_IRQ_MASK 8'h18
`define SPR_OFF_EXIT_GPA 8'h1c
`define SPR_OFF_EXIT_GLA 8'h20
`define SPR_OFF_EXIT_INFO 8'h24
`define SPR_OFF_OPERAND_HI 8'h28

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define SPR_CTRL_GO_BIT  0
`define SPR_LEAF_REMOVE  8'h03
`define SPR_LEAF_TRACK   8'h0c
`define SPR_PAGE_MASK    12'hfff
`define SPR_RES_OK       8'h00
`define SPR_RES_CHILD    8'h0d
`define SPR_RES_ACTIVE   8'h0e
`define SPR_EXIT_REASON  8'h3c
`define SPR_QUAL_CONFLICT 8'h00
`define SPR_LOOKUP_NS    100
`define SPR_LOOKUP_CYC   ((`SPR_LOOKUP_NS + 99) / 100)

`endif

// >>> pkg/spr_pkg.sv
// Types of the secure page removal unit.
package spr_pkg;

  typedef enum logic [2:0] {
    SPR_CONTROL_STRUCTURE_TYPE,
    SPR_THREAD_CONTROL_TYPE,
    SPR_REGULAR_PAGE_TYPE,
    SPR_VERSION_ARRAY_TYPE,
    SPR_TRIMMED_PAGE_TYPE,
    SPR_SHADOW_STACK_FIRST_TYPE,
    SPR_SHADOW_STACK_REST_TYPE
  } spr_page_type_t;

  // Page-map entry as read from the map.
  typedef struct packed {
    logic           valid;
    logic           modified;
    spr_page_type_t ptype;
  } spr_map_entry_t;

  // Lookup answer: entry plus the facts the checks need.
  typedef struct packed {
    logic           in_cache;
    logic           conflict;
    logic           child_present;
    logic           virt_child_nz;
    logic           enclave_active;
    logic           access_pf;
    logic [15:0]    pf_code;
    logic [63:0]    phys_addr;
    spr_map_entry_t entry;
  } spr_lookup_t;

  typedef enum logic [1:0] {
    SPR_FLT_NONE,
    SPR_FLT_GP,
    SPR_FLT_PF,
    SPR_FLT_VMEXIT
  } spr_fault_t;

  // Arithmetic flag set produced by a leaf.
  typedef struct packed {
    logic zf;
    logic cf;
    logic pf;
    logic af;
    logic of;
    logic sf;
  } spr_flags_t;

  // Core mode as seen while the leaf runs.
  typedef struct packed {
    logic [1:0]  cpl;
    logic        long_mode;
    logic        vm_guest;
    logic        virt_ext;
    logic [31:0] ds_base;
    logic [31:0] ds_limit;
  } spr_mode_t;

endpackage

// >>> dv/test_secure_page_removal_unit.sv
// Self-checking bench of the secure page removal unit, driving its ports directly.
`timescale 1ns/1ps
`include "spr_regs.svh"

module test_secure_page_removal_unit;
  logic                 clk_sys;
  logic                 rst_n;
  logic [7:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [31:0]          reg_rdata;
  logic [7:0]           leaf_sel;
  spr_pkg::spr_mode_t   mode;
  logic                 lookup_req;
  logic [63:0]          lookup_addr;
  spr_pkg::spr_lookup_t rsp;
  logic                 map_clear;
  logic [63:0]          map_addr;
  logic                 track_start;
  logic                 irq;
  int                   n_mismatch;
  int                   compares;
  int                   n_look;
  int                   n_clear;
  int                   n_track;
  logic [63:0]          look_addr;
  logic [31:0]          rd;
  logic [31:0]          base;

  spr_unit spr_unit_i (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .leaf_sel    (leaf_sel),
    .core_mode   (mode),
    .lookup_req  (lookup_req),
    .lookup_addr (lookup_addr),
    .lookup_rsp  (rsp),
    .map_clear   (map_clear),
    .map_addr    (map_addr),
    .track_start (track_start),
    .irq         (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Port monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (lookup_req === 1'b1) begin
      n_look++;
      look_addr = lookup_addr;
    end
    if (map_clear === 1'b1) n_clear++;
    if (track_start === 1'b1) n_track++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task rdr(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task md(input logic [1:0] cpl, input logic g, input logic x, input logic [31:0] lim);
    mode <= '{cpl, 1'b0, g, x, base, lim};
  endtask

  task rs(input logic c, input logic cf, input logic ch, input logic vc, input logic act,
          input logic apf, input logic v, input logic m, input spr_pkg::spr_page_type_t t);
    rsp <= '{c, cf, ch, vc, act, apf, 16'h00a5, 64'h0000_0000_00ab_c000, '{v, m, t}};
  endtask

  // The busy poll is bounded, so a hung operation ends the run instead of stalling it.
  task run(input logic [31:0] op, input logic [7:0] leaf);
    int i;
    leaf_sel <= leaf;
    wr(`SPR_OFF_OPERAND, op);
    n_look  = 0;
    n_clear = 0;
    n_track = 0;
    wr(`SPR_OFF_CTRL, 32'h0000_0001);
    for (i = 0; i < 8; i++) begin
      rdr(`SPR_OFF_CTRL);
      if (rd[0] === 1'b0) break;
    end
    if (i == 8) begin
      n_mismatch++;
      $display("BAD busy expected 0 seen 1");
      end_of_test;
    end
  endtask

  task out(input logic [1:0] f, input logic [7:0] res, input logic zf, input int clr);
    rdr(`SPR_OFF_STATUS);
    chk("fault", f, rd[1:0]);
    rdr(`SPR_OFF_RESULT);
    chk("result", res, rd);
    rdr(`SPR_OFF_FLAGS);
    chk("flags", {zf, 5'h00}, rd[5:0]);
    chk("clears", clr, n_clear);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task sc_types;
    spr_pkg::spr_page_type_t kinds[5];
    kinds = '{spr_pkg::SPR_REGULAR_PAGE_TYPE, spr_pkg::SPR_THREAD_CONTROL_TYPE, spr_pkg::SPR_TRIMMED_PAGE_TYPE,
              spr_pkg::SPR_SHADOW_STACK_FIRST_TYPE, spr_pkg::SPR_SHADOW_STACK_REST_TYPE};
    md(2'h0, 1'b0, 1'b0, 32'hffff_ffff);
    rs(1, 0, 0, 0, 0, 0, 1, 0, spr_pkg::SPR_VERSION_ARRAY_TYPE);
    run(32'h0000_3000, `SPR_LEAF_REMOVE);
    out(2'h0, 8'h00, 1'b0, 1);
    chk("linear", base + 32'h0000_3000, look_addr);
    rs(1, 0, 0, 0, 0, 0, 0, 1, spr_pkg::SPR_REGULAR_PAGE_TYPE);
    run(32'h0000_3000, `SPR_LEAF_REMOVE);
    out(2'h0, 8'h00, 1'b0, 0);
    rs(1, 0, 0, 0, 0, 0, 1, 0, spr_pkg::SPR_TRIMMED_PAGE_TYPE);
    run(32'h0000_3000, `SPR_LEAF_REMOVE);
    out(2'h0, 8'h00, 1'b0, 0);
    foreach (kinds[k]) begin
      rs(1, 0, 0, 0, 0, 0, 1, 1, kinds[k]);
      run(32'h0000_5000, `SPR_LEAF_REMOVE);
      out(2'h0, 8'h00, 1'b0, 1);
    end
    rs(1, 0, 0, 0, 1, 0, 1, 1, spr_pkg::SPR_THREAD_CONTROL_TYPE);
    run(32'h0000_5000, `SPR_LEAF_REMOVE);
    out(2'h0, `SPR_RES_ACTIVE, 1'b1, 0);
  endtask

  task sc_enclave_control_structure;
    rs(1, 0, 0, 1, 0, 0, 1, 0, spr_pkg::SPR_CONTROL_STRUCTURE_TYPE);
    run(32'h0000_6000, `SPR_LEAF_REMOVE);
    out(2'h0, 8'h00, 1'b0, 1);
    md(2'h0, 1'b1, 1'b1, 32'hffff_ffff);
    run(32'h0000_6000, `SPR_LEAF_REMOVE);
    out(2'h0, `SPR_RES_CHILD, 1'b1, 0);
    rs(1, 0, 0, 0, 0, 0, 1, 0, spr_pkg::SPR_CONTROL_STRUCTURE_TYPE);
    run(32'h0000_6000, `SPR_LEAF_REMOVE);
    out(2'h0, 8'h00, 1'b0, 1);
    rs(1, 0, 1, 0, 0, 0, 1, 0, spr_pkg::SPR_CONTROL_STRUCTURE_TYPE);
    run(32'h0000_6000, `SPR_LEAF_REMOVE);
    out(2'h0, `SPR_RES_CHILD, 1'b1, 0);
  endtask

  // Faults follow an error exit, so result and flags must still show it.
  task sc_faults;
    rs(0, 1, 0, 0, 0, 1, 1, 0, spr_pkg::SPR_REGULAR_PAGE_TYPE);
    run(32'h0000_7004, `SPR_LEAF_REMOVE);
    out(2'h1, `SPR_RES_CHILD, 1'b1, 0);
    rdr(`SPR_OFF_EXIT_GLA);
    chk("gp address", 32'h0000_0000, rd);
    rdr(`SPR_OFF_STATUS);
    chk("gp code", 16'h0000, rd[31:16]);
    run(32'h0000_7000, `SPR_LEAF_REMOVE);
    out(2'h2, `SPR_RES_CHILD, 1'b1, 0);
    rdr(`SPR_OFF_STATUS);
    chk("pf code", 16'h00a5, rd[31:16]);
    rs(0, 1, 0, 0, 0, 0, 1, 0, spr_pkg::SPR_REGULAR_PAGE_TYPE);
    run(32'h0000_7000, `SPR_LEAF_REMOVE);
    out(2'h2, `SPR_RES_CHILD, 1'b1, 0);
    rdr(`SPR_OFF_EXIT_GLA);
    chk("pf address", base + 32'h0000_7000, rd);
    rs(1, 1, 0, 0, 0, 0, 0, 0, spr_pkg::SPR_REGULAR_PAGE_TYPE);
    run(32'h0000_7000, `SPR_LEAF_REMOVE);
    out(2'h3, `SPR_RES_CHILD, 1'b1, 0);
    rdr(`SPR_OFF_EXIT_GPA);
    chk("exit gpa", 32'h00ab_c000, rd);
    rdr(`SPR_OFF_EXIT_GLA);
    chk("exit gla", base + 32'h0000_7000, rd);
    rdr(`SPR_OFF_EXIT_INFO);
    chk("exit info", {16'h0000, `SPR_QUAL_CONFLICT, `SPR_EXIT_REASON}, rd);
    md(2'h0, 1'b0, 1'b1, 32'h0000_6fff);
    run(32'h0000_7000, `SPR_LEAF_REMOVE);
    out(2'h1, `SPR_RES_CHILD, 1'b1, 0);
    md(2'h0, 1'b0, 1'b1, 32'hffff_ffff);
    run(32'h0000_7000, `SPR_LEAF_REMOVE);
    out(2'h1, `SPR_RES_CHILD, 1'b1, 0);
    md(2'h3, 1'b0, 1'b0, 32'hffff_ffff);
    run(32'h0000_7000, `SPR_LEAF_REMOVE);
    out(2'h1, `SPR_RES_CHILD, 1'b1, 0);
    chk("lookups", 0, n_look);
    mode <= '{2'h0, 1'b1, 1'b0, 1'b0, base, 32'h0000_6fff};
    rs(1, 0, 0, 0, 0, 0, 1, 0, spr_pkg::SPR_VERSION_ARRAY_TYPE);
    wr(`SPR_OFF_OPERAND_HI, 32'h0001_0000);
    run(32'h0000_7000, `SPR_LEAF_REMOVE);
    out(2'h1, `SPR_RES_CHILD, 1'b1, 0);
    wr(`SPR_OFF_OPERAND_HI, 32'h0000_0000);
    run(32'h0000_7000, `SPR_LEAF_REMOVE);
    out(2'h0, 8'h00, 1'b0, 1);
    md(2'h3, 1'b0, 1'b0, 32'hffff_ffff);
  endtask

  task sc_track;
    run(32'h0000_6000, `SPR_LEAF_TRACK);
    chk("track", 0, n_track);
    rdr(`SPR_OFF_STATUS);
    chk("fault", 2'h1, rd[1:0]);
    md(2'h0, 1'b0, 1'b0, 32'hffff_ffff);
    run(32'h0000_6000, `SPR_LEAF_TRACK);
    chk("track", 1, n_track);
    out(2'h0, 8'h00, 1'b0, 0);
    run(32'h0000_6000, 8'h05);
    chk("lookups", 0, n_look);
    chk("track", 0, n_track);
    rdr(8'h40);
    chk("unmapped", 32'h0000_0000, rd);
  endtask

  task sc_irq;
    wr(`SPR_OFF_IRQ_STAT, 32'h0000_000f);
    wr(`SPR_OFF_IRQ_MASK, 32'h0000_0001);
    #1 chk("irq", 1'b0, irq);
    rs(1, 0, 0, 0, 0, 0, 1, 0, spr_pkg::SPR_VERSION_ARRAY_TYPE);
    run(32'h0000_3000, `SPR_LEAF_REMOVE);
    chk("irq", 1'b1, irq);
    rdr(`SPR_OFF_IRQ_STAT);
    chk("irq stat", 32'h0000_0001, rd);
    wr(`SPR_OFF_IRQ_STAT, 32'h0000_0001);
    #1 chk("irq", 1'b0, irq);
    wr(`SPR_OFF_IRQ_MASK, 32'h0000_0004);
    run(32'h0000_3008, `SPR_LEAF_REMOVE);
    chk("irq", 1'b1, irq);
    wr(`SPR_OFF_IRQ_MASK, 32'h0000_0002);
    #1 chk("irq", 1'b0, irq);
    rdr(`SPR_OFF_IRQ_STAT);
    chk("irq stat", 32'h0000_0004, rd);
  endtask

  initial begin
    rst_n      = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0000_0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    leaf_sel   = 8'h00;
    mode       = '0;
    rsp        = '0;
    base       = 32'h0001_0000;
    n_mismatch = 0;
    compares   = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    sc_types;
    sc_enclave_control_structure;
    sc_faults;
    sc_track;
    sc_irq;
    end_of_test;
  end
endmodule
